// file: rtl/cmst_pkg.sv
// Package with register map, field positions and reset values of the CAN status block.
package cmst_pkg;
   localparam logic [11:0] CMST_OFS_FLAGS = 12'h050;
   localparam logic [11:0] CMST_OFS_CTRL = 12'h018;
   localparam logic [11:0] CMST_OFS_NDAT_LO = 12'h098;
   localparam logic [11:0] CMST_OFS_NDAT_UP = 12'h09c;
   localparam logic [11:0] CMST_OFS_TXW0 = 12'h0c0;
   localparam logic [11:0] CMST_OFS_TXW1 = 12'h0c4;
   localparam logic [11:0] CMST_OFS_TXW2 = 12'h0c8;
   localparam logic [11:0] CMST_OFS_TXW3 = 12'h0cc;
   localparam logic [11:0] CMST_OFS_TXSTAT = 12'h0d0;
   localparam int CMST_BIT_UNCORR = 21;
   localparam int CMST_BIT_CORR = 20;
   localparam int CMST_BIT_DEDSTORE = 19;
   localparam int CMST_BIT_ACCFAIL = 17;
   localparam int CMST_BIT_INIT = 0;
   localparam int CMST_BIT_FDENA = 8;
   localparam int CMST_BIT_RATESW_ENA = 9;
   localparam int CMST_BIT_ESIR = 10;
   localparam int CMST_BIT_EXT_ID = 30;
   localparam int CMST_BIT_RTR = 29;
   localparam int CMST_ID_STD_LSB = 18;
   localparam int CMST_BIT_EVT_STORE = 23;
   localparam int CMST_BIT_FDF = 21;
   localparam int CMST_BIT_BRS = 20;
   localparam int CMST_MARKER_LSB = 24;
   localparam int CMST_DLC_LSB = 16;
   localparam logic [31:0] CMST_RST_CTRL = 32'h0000_0001;
   localparam logic [31:0] CMST_RST_ZERO = 32'h0000_0000;
   localparam logic [3:0] CMST_DLC_CLASSIC_MAX = 4'h8;
   localparam logic [6:0] CMST_BYTES_CLASSIC_MAX = 7'h08;
endpackage : cmst_pkg

// file: rtl/cmst_dlc_decode.sv
// Data length code to payload byte count decoder.
`timescale 1ns/1ns
module cmst_dlc_decode
   import cmst_pkg::*;
(
   // Code and format.
   input wire logic [3:0] dlc_in,
   input wire logic fd_in,
   // Byte count.
   output logic [6:0] bytes_out
);
   always_comb begin
      if (dlc_in <= CMST_DLC_CLASSIC_MAX) begin
         bytes_out = {3'h0, dlc_in};
      end else if (!fd_in) begin
         bytes_out = CMST_BYTES_CLASSIC_MAX;
      end else begin
         case (dlc_in)
            4'h9: bytes_out = 7'h0c;
            4'ha: bytes_out = 7'h10;
            4'hb: bytes_out = 7'h14;
            4'hc: bytes_out = 7'h18;
            4'hd: bytes_out = 7'h20;
            4'he: bytes_out = 7'h30;
            default: bytes_out = 7'h40;
         endcase
      end
   end
endmodule : cmst_dlc_decode

// file: rtl/cmst_sticky_flags.sv
// Bank of sticky flags, set by hardware pulses, cleared by writing one.
`timescale 1ns/1ns
module cmst_sticky_flags #(
   parameter int WIDTH = 32
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Set and clear.
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] clr_in,
   // Flags.
   output logic [WIDTH-1:0] flags_out
);
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one.");
   end
   for (genvar i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            flags_out[i] <= 1'b0;
         end else if (set_in[i]) begin
            flags_out[i] <= 1'b1;
         end else if (clr_in[i]) begin
            flags_out[i] <= 1'b0;
         end
      end
   end
endmodule : cmst_sticky_flags

// file: rtl/cmst_top.sv
// CAN message RAM status flags, new-data flags and Tx element decode behind AHB-Lite.
`timescale 1ns/1ns
module cmst_top
   import cmst_pkg::*;
(
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // AHB-Lite slave.
   input wire logic hsel_in,
   input wire logic [11:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Message RAM and Rx handler events, one-cycle pulses.
   input wire logic ram_err_uncorr_in,
   input wire logic ram_err_corr_in,
   input wire logic dedicated_store_in,
   input wire logic rx_late_in,
   input wire logic rx_write_fail_in,
   input wire logic [31:0] rxbuf_update_in,
   // Protocol engine state.
   input wire logic error_passive_in,
   // Protocol engine controls.
   output logic init_control_bit_out,
   output logic rx_abort_out,
   output logic rx_restart_out,
   // Decoded Tx element.
   output logic tx_extended_out,
   output logic tx_remote_out,
   output logic [28:0] tx_id_out,
   output logic [7:0] tx_marker_out,
   output logic tx_event_store_out,
   output logic tx_fd_out,
   output logic tx_brs_out,
   output logic tx_esi_out,
   output logic [6:0] tx_bytes_out,
   output logic [7:0] payload_byte_zero_out
);
   import cmst_pkg::*;

   logic rst_s1;
   logic rst_n;
   logic ph_valid;
   logic ph_write;
   logic [11:0] ph_addr;
   logic [31:0] ctrl;
   logic [31:0] txw0;
   logic [31:0] txw1;
   logic [31:0] txw2;
   logic [31:0] txw3;
   logic [31:0] ndat_lo;
   logic [31:0] ndat_up;
   logic [31:0] flags;
   logic [31:0] flag_set;
   logic [31:0] flag_clr;
   logic [31:0] ndlo_clr;
   logic [31:0] ndup_clr;
   logic [31:0] next_rdata;
   logic [6:0] dec_bytes;
   logic wr_go;
   logic fd_eff;
   logic brs_eff;

   // Reset release through two flip-flops.
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Address phase capture; the slave never stalls.
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 12'h000;
      end else if (hready_in) begin
         ph_valid <= hsel_in & htrans_in[1];
         ph_write <= hwrite_in;
         ph_addr <= haddr_in;
      end
   end

   assign wr_go = ph_valid & ph_write;

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // Control register and Tx element words.
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CMST_RST_CTRL;
      end else if (ram_err_uncorr_in) begin
         ctrl[CMST_BIT_INIT] <= 1'b1;
      end else if (wr_go && ph_addr == CMST_OFS_CTRL) begin
         ctrl <= hwdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         txw0 <= CMST_RST_ZERO;
         txw1 <= CMST_RST_ZERO;
         txw2 <= CMST_RST_ZERO;
         txw3 <= CMST_RST_ZERO;
      end else if (wr_go) begin
         if (ph_addr == CMST_OFS_TXW0) begin
            txw0 <= hwdata_in;
         end else if (ph_addr == CMST_OFS_TXW1) begin
            txw1 <= hwdata_in;
         end else if (ph_addr == CMST_OFS_TXW2) begin
            txw2 <= hwdata_in;
         end else if (ph_addr == CMST_OFS_TXW3) begin
            txw3 <= hwdata_in;
         end
      end
   end

   // Status flags: RAM errors, dedicated store and access failure.
   always_comb begin
      flag_set = 32'h0000_0000;
      flag_set[CMST_BIT_UNCORR] = ram_err_uncorr_in;
      flag_set[CMST_BIT_CORR] = ram_err_corr_in;
      flag_set[CMST_BIT_DEDSTORE] = dedicated_store_in;
      flag_set[CMST_BIT_ACCFAIL] = rx_late_in | rx_write_fail_in;
   end

   assign flag_clr = (wr_go && ph_addr == CMST_OFS_FLAGS) ? hwdata_in : 32'h0000_0000;
   assign ndlo_clr = (wr_go && ph_addr == CMST_OFS_NDAT_LO) ? hwdata_in : 32'h0000_0000;
   assign ndup_clr = (wr_go && ph_addr == CMST_OFS_NDAT_UP) ? hwdata_in : 32'h0000_0000;

   cmst_sticky_flags #(.WIDTH(32)) u_flags (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .set_in(flag_set),
      .clr_in(flag_clr),
      .flags_out(flags)
   );

   cmst_sticky_flags #(.WIDTH(32)) u_ndat_lo (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .set_in(rxbuf_update_in),
      .clr_in(ndlo_clr),
      .flags_out(ndat_lo)
   );

   // The upper bank has no buffers feeding it in this block.
   cmst_sticky_flags #(.WIDTH(32)) u_ndat_up (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .set_in(32'h0000_0000),
      .clr_in(ndup_clr),
      .flags_out(ndat_up)
   );

   // Tx element decode.
   assign fd_eff = ctrl[CMST_BIT_FDENA] & txw1[CMST_BIT_FDF] & ~txw0[CMST_BIT_RTR];
   assign brs_eff = fd_eff & ctrl[CMST_BIT_RATESW_ENA] & txw1[CMST_BIT_BRS];

   cmst_dlc_decode u_dlc (
      .dlc_in(txw1[CMST_DLC_LSB +: 4]),
      .fd_in(fd_eff),
      .bytes_out(dec_bytes)
   );

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_extended_out <= 1'b0;
         tx_remote_out <= 1'b0;
         tx_id_out <= 29'h0;
         tx_marker_out <= 8'h00;
         tx_event_store_out <= 1'b0;
         tx_fd_out <= 1'b0;
         tx_brs_out <= 1'b0;
         tx_esi_out <= 1'b0;
         tx_bytes_out <= 7'h00;
         payload_byte_zero_out <= 8'h00;
      end else begin
         tx_extended_out <= txw0[CMST_BIT_EXT_ID];
         tx_remote_out <= txw0[CMST_BIT_RTR];
         tx_id_out <= txw0[CMST_BIT_EXT_ID] ? txw0[28:0]
                      : {txw0[28:CMST_ID_STD_LSB], 18'h0};
         tx_marker_out <= txw1[CMST_MARKER_LSB +: 8];
         tx_event_store_out <= txw1[CMST_BIT_EVT_STORE];
         tx_fd_out <= fd_eff;
         tx_brs_out <= brs_eff;
         tx_esi_out <= ctrl[CMST_BIT_FDENA] & (error_passive_in | ctrl[CMST_BIT_ESIR]);
         tx_bytes_out <= txw0[CMST_BIT_RTR] ? 7'h00 : dec_bytes;
         payload_byte_zero_out <= txw2[7:0];
      end
   end

   // Protocol engine controls.
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         init_control_bit_out <= 1'b1;
         rx_abort_out <= 1'b0;
         rx_restart_out <= 1'b0;
      end else begin
         init_control_bit_out <= ctrl[CMST_BIT_INIT] | ram_err_uncorr_in;
         rx_abort_out <= rx_late_in | rx_write_fail_in;
         rx_restart_out <= rx_late_in;
      end
   end

   // Read data is decoded in the address phase and registered, so it stands in the data phase.
   // A read straight behind a write to the same register still returns the old value.
   always_comb begin
      if (haddr_in == CMST_OFS_FLAGS) begin
         next_rdata = flags;
      end else if (haddr_in == CMST_OFS_CTRL) begin
         next_rdata = ctrl;
      end else if (haddr_in == CMST_OFS_NDAT_LO) begin
         next_rdata = ndat_lo;
      end else if (haddr_in == CMST_OFS_NDAT_UP) begin
         next_rdata = ndat_up;
      end else if (haddr_in == CMST_OFS_TXW0) begin
         next_rdata = txw0;
      end else if (haddr_in == CMST_OFS_TXW1) begin
         next_rdata = txw1;
      end else if (haddr_in == CMST_OFS_TXW2) begin
         next_rdata = txw2;
      end else if (haddr_in == CMST_OFS_TXW3) begin
         next_rdata = txw3;
      end else if (haddr_in == CMST_OFS_TXSTAT) begin
         next_rdata = {tx_marker_out, 17'h0, tx_bytes_out};
      end else begin
         next_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_out <= 32'h0000_0000;
      end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
         hrdata_out <= next_rdata;
      end
   end

   // Assertions.
   property p_uncorr_init;
      @(posedge mclk_in) disable iff (!rst_n) ram_err_uncorr_in |=> ctrl[CMST_BIT_INIT] && init_control_bit_out;
   endproperty
   a_uncorr_init: assert property (p_uncorr_init) else $error("Init not forced by uncorrected error.");

   property p_uncorr_flag;
      @(posedge mclk_in) disable iff (!rst_n) ram_err_uncorr_in |=> flags[CMST_BIT_UNCORR];
   endproperty
   a_uncorr_flag: assert property (p_uncorr_flag) else $error("Uncorrected flag not set.");

   property p_corr_flag;
      @(posedge mclk_in) disable iff (!rst_n) ram_err_corr_in |=> flags[CMST_BIT_CORR];
   endproperty
   a_corr_flag: assert property (p_corr_flag) else $error("Corrected flag not set.");

   property p_dedstore_flag;
      @(posedge mclk_in) disable iff (!rst_n) dedicated_store_in |=> flags[CMST_BIT_DEDSTORE];
   endproperty
   a_dedstore_flag: assert property (p_dedstore_flag) else $error("Dedicated store flag not set.");

   property p_flag_hold;
      @(posedge mclk_in) disable iff (!rst_n)
         (flags & ~flag_clr) != 32'h0000_0000 |=> (flags & $past(flags & ~flag_clr)) == $past(flags & ~flag_clr);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Status flag lost without a clear.");

   sequence s_late;
      rx_late_in ##1 (rx_abort_out && rx_restart_out);
   endsequence
   property p_late;
      @(posedge mclk_in) disable iff (!rst_n) rx_late_in |-> s_late ##0 flags[CMST_BIT_ACCFAIL];
   endproperty
   a_late: assert property (p_late) else $error("Late handler not aborted.");

   property p_wfail;
      @(posedge mclk_in) disable iff (!rst_n) rx_write_fail_in |=> rx_abort_out && flags[CMST_BIT_ACCFAIL];
   endproperty
   a_wfail: assert property (p_wfail) else $error("Write failure not flagged.");

   property p_nd_set;
      @(posedge mclk_in) disable iff (!rst_n) rxbuf_update_in[0] |=> ndat_lo[0];
   endproperty
   a_nd_set: assert property (p_nd_set) else $error("New data flag not set.");

   property p_nd_hold;
      @(posedge mclk_in) disable iff (!rst_n) ndat_lo[0] && !ndlo_clr[0] |=> ndat_lo[0];
   endproperty
   a_nd_hold: assert property (p_nd_hold) else $error("New data flag lost.");

   property p_nd_clear;
      @(posedge mclk_in) disable iff (!rst_n) ndat_lo[0] && ndlo_clr[0] && !rxbuf_update_in[0] |=> !ndat_lo[0];
   endproperty
   a_nd_clear: assert property (p_nd_clear) else $error("New data flag not cleared by one.");

   property p_remote_classic;
      @(posedge mclk_in) disable iff (!rst_n) tx_remote_out |-> !tx_fd_out && !tx_brs_out;
   endproperty
   a_remote_classic: assert property (p_remote_classic) else $error("Remote frame in FD format.");

   property p_esi_passive;
      @(posedge mclk_in) disable iff (!rst_n)
         $stable(error_passive_in) && error_passive_in && ctrl[CMST_BIT_FDENA] && $stable(ctrl) |=> tx_esi_out;
   endproperty
   a_esi_passive: assert property (p_esi_passive) else $error("ESI not recessive when passive.");
endmodule : cmst_top

// file: sim/cmst_rx_source.sv
// Model of the Rx handler and message RAM check logic that raise one-cycle event pulses.
`timescale 1ns/1ns
module cmst_rx_source (
   // Clock and command from the bench.
   input wire logic clk_in,
   input wire logic cmd_valid_in,
   input wire logic [2:0] cmd_kind_in,
   input wire logic [4:0] cmd_buf_in,
   // Event pulses towards the block.
   output logic ram_err_uncorr_out = 1'b0,
   output logic ram_err_corr_out = 1'b0,
   output logic dedicated_store_out = 1'b0,
   output logic rx_late_out = 1'b0,
   output logic rx_write_fail_out = 1'b0,
   output logic [31:0] rxbuf_update_out = 32'h0000_0000
);
   // Each command of kind 0 to 5 yields exactly one pulse of one clock, then the line returns low.
   always @(posedge clk_in) begin
      ram_err_uncorr_out <= cmd_valid_in && cmd_kind_in == 3'h0;
      ram_err_corr_out <= cmd_valid_in && cmd_kind_in == 3'h1;
      dedicated_store_out <= cmd_valid_in && cmd_kind_in == 3'h2;
      rx_late_out <= cmd_valid_in && cmd_kind_in == 3'h3;
      rx_write_fail_out <= cmd_valid_in && cmd_kind_in == 3'h4;
      rxbuf_update_out <= (cmd_valid_in && cmd_kind_in == 3'h5) ? (32'h1 << cmd_buf_in) : 32'h0;
   end
endmodule : cmst_rx_source

// file: sim/testbench.sv
// Self-checking bench for the CAN status block: event flags, new-data bank and Tx element decode.
`timescale 1ns/1ns
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin mismatches++; $display("wrong value at %0t: got %h, expected %h", $time, act, exp); end end
module testbench;
   import cmst_pkg::*;
   localparam logic [31:0] ev_flag [0:4] = '{32'h0020_0000, 32'h0010_0000, 32'h0008_0000, 32'h0002_0000, 32'h0002_0000};
   localparam logic [1:0] ev_abort [0:4] = '{2'b00, 2'b00, 2'b00, 2'b11, 2'b10};
   logic mclk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic err_pass = 1'b0;
   logic cmd_v = 1'b0;
   logic [2:0] cmd_kind = 3'h0;
   logic [4:0] cmd_buf = 5'h00;
   logic rd_dphase = 1'b0;
   logic port_take = 1'b0;
   logic [31:0] seed = 32'ha81e;
   int mismatches = 0;
   int cmp_count = 0;
   logic [31:0] exp_q [$];
   int sel_q [$];
   logic [31:0] hrdata;
   logic hreadyout, hresp, init_ctl, rx_abort, rx_restart, tx_ext, tx_rem, tx_evt, tx_fd, tx_brs, tx_esi;
   logic [28:0] tx_id;
   logic [7:0] tx_mark, tx_b0;
   logic [6:0] tx_bytes;
   logic p_unc, p_cor, p_ded, p_late, p_fail;
   logic [31:0] p_upd;
   logic [31:0] view [0:5];
   assign view[0] = hrdata;
   assign view[1] = {8'h00, tx_ext, tx_rem, tx_fd, tx_brs, tx_esi, tx_evt, init_ctl, rx_abort, rx_restart, tx_bytes, tx_b0};
   assign view[2] = {3'b000, tx_id};
   assign view[3] = {24'h0, tx_mark};
   assign view[4] = {29'h0, hresp, rx_abort, rx_restart};
   assign view[5] = {31'h0, init_ctl};

   cmst_rx_source partner (.clk_in(mclk_in), .cmd_valid_in(cmd_v), .cmd_kind_in(cmd_kind), .cmd_buf_in(cmd_buf),
      .ram_err_uncorr_out(p_unc), .ram_err_corr_out(p_cor), .dedicated_store_out(p_ded), .rx_late_out(p_late),
      .rx_write_fail_out(p_fail), .rxbuf_update_out(p_upd));

   cmst_top dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
      .hreadyout_out(hreadyout), .hresp_out(hresp), .ram_err_uncorr_in(p_unc), .ram_err_corr_in(p_cor),
      .dedicated_store_in(p_ded), .rx_late_in(p_late), .rx_write_fail_in(p_fail), .rxbuf_update_in(p_upd),
      .error_passive_in(err_pass), .init_control_bit_out(init_ctl), .rx_abort_out(rx_abort),
      .rx_restart_out(rx_restart), .tx_extended_out(tx_ext), .tx_remote_out(tx_rem), .tx_id_out(tx_id),
      .tx_marker_out(tx_mark), .tx_event_store_out(tx_evt), .tx_fd_out(tx_fd), .tx_brs_out(tx_brs),
      .tx_esi_out(tx_esi), .tx_bytes_out(tx_bytes), .payload_byte_zero_out(tx_b0));

   initial begin
      forever #4 mclk_in = ~mclk_in;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [6:0] nbytes(input logic [3:0] d, input logic fd);
      if (d <= 4'h8) return {3'b000, d};
      if (!fd) return 7'h08;
      case (d)
         4'h9: return 7'd12;
         4'ha: return 7'd16;
         4'hb: return 7'd20;
         4'hc: return 7'd24;
         4'hd: return 7'd32;
         4'he: return 7'd48;
         default: return 7'd64;
      endcase
   endfunction : nbytes

   // The outputs are sampled before this edge's updates land, so each note sees the settled cycle.
   always @(posedge mclk_in) begin
      int s;
      logic [31:0] e;
      if ((rd_dphase && hreadyout === 1'b1) || port_take) begin
         s = sel_q.pop_front();
         e = exp_q.pop_front();
         `CHK(view[s], e)
      end
   end

   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      @(posedge mclk_in);
      while (hreadyout !== 1'b1) @(posedge mclk_in);
      htrans <= 2'b00;
      hwdata <= d;
      rd_dphase <= !wr;
      @(posedge mclk_in);
      while (hreadyout !== 1'b1) @(posedge mclk_in);
      rd_dphase <= 1'b0;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      sel_q.push_back(0);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic pchk(input int s, input logic [31:0] e);
      exp_q.push_back(e);
      sel_q.push_back(s);
      port_take <= 1'b1;
      @(posedge mclk_in);
      port_take <= 1'b0;
      @(posedge mclk_in);
   endtask : pchk

   task automatic ev(input logic [2:0] k, input logic [4:0] b);
      @(posedge mclk_in);
      cmd_v <= 1'b1;
      cmd_kind <= k;
      cmd_buf <= b;
      @(posedge mclk_in);
      cmd_v <= 1'b0;
      @(posedge mclk_in);
   endtask : ev

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge mclk_in);
      mismatches++;
      complete_run();
   end

   initial begin
      logic [31:0] w0, w1, w2, c, r, m;
      logic fd, brs, esi;
      logic [6:0] nb;
      repeat (16) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rd(CMST_OFS_CTRL, CMST_RST_CTRL);
      rd(CMST_OFS_FLAGS, 32'h0);
      rd(CMST_OFS_NDAT_LO, 32'h0);
      rd(CMST_OFS_NDAT_UP, 32'h0);
      wr(12'h0fc, 32'hffff_ffff);
      rd(12'h0fc, 32'h0);
      wr(CMST_OFS_CTRL, 32'h0);
      @(posedge mclk_in);
      pchk(5, 32'h0);
      for (int k = 0; k < 5; k++) begin
         ev(k[2:0], 5'h00);
         pchk(4, {30'h0, ev_abort[k]});
         wr(CMST_OFS_FLAGS, 32'h0);
         rd(CMST_OFS_FLAGS, ev_flag[k]);
         if (k == 0) pchk(5, 32'h1);
         wr(CMST_OFS_FLAGS, ev_flag[k]);
         rd(CMST_OFS_FLAGS, 32'h0);
      end
      wr(CMST_OFS_CTRL, 32'h0);
      ev(3'h5, 5'd0);
      ev(3'h5, 5'd31);
      m = 32'h8000_0001;
      repeat (6) begin
         r = rnd();
         ev(3'h5, r[4:0]);
         m = m | (32'h1 << r[4:0]);
      end
      rd(CMST_OFS_NDAT_LO, m);
      wr(CMST_OFS_NDAT_LO, 32'h0);
      rd(CMST_OFS_NDAT_LO, m);
      c = m & (rnd() | 32'h0000_0001);
      wr(CMST_OFS_NDAT_LO, c);
      rd(CMST_OFS_NDAT_LO, m & ~c);
      rd(CMST_OFS_NDAT_UP, 32'h0);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rd(CMST_OFS_NDAT_LO, 32'h0);
      wr(CMST_OFS_CTRL, 32'h0);
      for (int i = 0; i < 64; i++) begin
         w0 = rnd();
         w1 = rnd();
         w2 = rnd();
         r = rnd();
         w0[29] = i[5];
         w1[19:16] = i[3:0];
         w1[21] = r[3] | r[4];
         c = 32'h0;
         c[8] = i[4];
         c[9] = r[0];
         c[10] = r[1];
         err_pass <= r[2];
         wr(CMST_OFS_TXW0, w0);
         wr(CMST_OFS_TXW1, w1);
         wr(CMST_OFS_TXW2, w2);
         wr(CMST_OFS_CTRL, c);
         repeat (2) @(posedge mclk_in);
         fd = c[8] & w1[21] & ~w0[29];
         brs = fd & c[9] & w1[20];
         esi = c[8] & (r[2] | c[10]);
         nb = w0[29] ? 7'h00 : nbytes(w1[19:16], fd);
         pchk(1, {8'h00, w0[30], w0[29], fd, brs, esi, w1[23], 3'b000, nb, w2[7:0]});
         pchk(2, w0[30] ? {3'b000, w0[28:0]} : {3'b000, w0[28:18], 18'h0});
         pchk(3, {24'h0, w1[31:24]});
         rd(CMST_OFS_TXSTAT, {w1[31:24], 17'h0, nb});
      end
      complete_run();
   end
endmodule : testbench
